// ---- pkg/clock_conditioner_map.svh ----
// clock_conditioner_map.svh: bit map, register offsets, timing constants
`ifndef CLOCK_CONDITIONER_MAP_SVH
`define CLOCK_CONDITIONER_MAP_SVH

// configuration word span
`define CFG_MSB        83
`define CFG_LSB        32
// configuration fields
`define IN_C_OSC_BIT   83
`define IN_B_OSC_BIT   82
`define IN_A_OSC_BIT   81
`define RESYNC_EN_BIT  80
`define IN_C_DYN_BIT   79
`define IN_B_DYN_BIT   78
`define IN_A_DYN_BIT   77
`define GEAR_MSB       76
`define GEAR_LSB       74
`define IN_C_MUX_BIT   73
`define IN_B_MUX_BIT   72
`define IN_A_MUX_BIT   71
`define LOC2_DLY_MSB   70
`define LOC2_DLY_LSB   66
`define LOC1_DLY_MSB   65
`define LOC1_DLY_LSB   61
`define GL2_DLY_MSB    60
`define GL2_DLY_LSB    56
`define GL1_DLY_MSB    55
`define GL1_DLY_LSB    51
`define PRI_DLY_MSB    50
`define PRI_DLY_LSB    46
`define SYS_DLY_BIT    45
`define FB_DLY_MSB     44
`define FB_DLY_LSB     40
`define FB_SEL_MSB     39
`define FB_SEL_LSB     38
`define TAP2_MSB       37
`define TAP2_LSB       35
`define TAP1_MSB       34
`define TAP1_LSB       32
// register byte offsets
`define REG_CTRL       8'h00
`define REG_STAGE_LO   8'h04
`define REG_STAGE_HI   8'h08
`define REG_ACTIVE_LO  8'h0C
`define REG_ACTIVE_HI  8'h10
`define REG_STATUS     8'h14
// control register fields
`define CTRL_UPDATE    0
`define CTRL_SRC_MSB   2
`define CTRL_SRC_LSB   1
`define CTRL_SEC1_LOC  3
`define CTRL_SEC2_LOC  4
// status register fields
`define STAT_LOCK      0
`define STAT_PD        1
// timing
`define CLOCK_MHZ      125
`define LOCK_TIME_NS   100000
// answers
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

// ---- pkg/clock_conditioner_pkg.sv ----
// clock_conditioner_pkg.sv: types of the clock conditioner configuration block
package clock_conditioner_pkg;
  // loop lock states, gray ordered
  typedef enum logic [1:0] {
    LOOP_DOWN   = 2'b00,
    LOOP_ACQ    = 2'b01,
    LOOP_LOCKED = 2'b11
  } loop_state_t;
  // feedback path choices
  typedef enum logic [1:0] {
    FB_NONE     = 2'b00,
    FB_PROG     = 2'b01,
    FB_EXTERNAL = 2'b10
  } fb_path_t;
  // reference input a sources
  typedef enum logic [1:0] {
    SRC_HARD_PAD = 2'b00,
    SRC_GEN_PAD  = 2'b01,
    SRC_CORE     = 2'b10
  } ref_src_t;
endpackage

// ---- hdl/clock_conditioner.sv ----
// configuration word, dynamic load and output routing
//
// Contract
// - five derived clocks, three independent settings
// - power-down input, lock output
// - at most three global buffers per circuit
// - primary always; secondaries global or local
// - bits 83..81 pick rc or crystal
// - bit 80 divider resync, read-only dynamically
// - bits 79..77 dynamic routing of inputs
// - bits 76..74 oscillator gear
// - bits 73..71 input mux selects
// - local output delays, five bits each
// - global output delays, five bits each
// - bit 45 inserts system delay
// - bits 44..40 feedback delay value
// - bits 39..38 feedback path select
// - bits 37..35 second phase tap
// - bits 34..32 first phase tap
// - load by jtag or shift register
// - reference a from three sources
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "clock_conditioner_map.svh"

module clock_conditioner
  import clock_conditioner_pkg::*;
#(
  parameter logic [51:0] STATIC_CONFIG = 52'h0,
  parameter int          LOCK_TIME_NS  = `LOCK_TIME_NS
) (
  // clock, reset, enable
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_clk_en,
  // axi4-lite write address
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [7:0]  i_s_axi_awaddr,
  // axi4-lite write data
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  // axi4-lite write response
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  output logic [1:0]       o_s_axi_bresp,
  // axi4-lite read address
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  input  wire logic [7:0]  i_s_axi_araddr,
  // axi4-lite read data
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  // dynamic shift port (jtag or user logic)
  input  wire logic        i_shift_en,
  input  wire logic        i_shift_data,
  output logic             o_shift_out,
  input  wire logic        i_config_update_strobe,
  // loop control
  input  wire logic        i_power_down,
  output logic             o_lock,
  output logic             o_divider_resync,
  // input selection
  output logic             o_input_c_osc_source_sel,
  output logic             o_input_b_osc_source_sel,
  output logic             o_input_a_osc_source_sel,
  output logic             o_input_c_dynamic_route,
  output logic             o_input_b_dynamic_route,
  output logic             o_input_a_dynamic_route,
  output logic             o_input_c_mux_sel,
  output logic             o_input_b_mux_sel,
  output logic             o_input_a_mux_sel,
  output logic [1:0]       o_reference_input_a_src,
  // oscillator and feedback
  output logic [2:0]       o_oscillator_gear,
  output logic             o_system_delay_insert,
  output logic [4:0]       o_feedback_delay_value,
  output logic [1:0]       o_feedback_path_sel,
  // output delays
  output logic [4:0]       o_primary_out_delay,
  output logic [4:0]       o_global1_out_delay,
  output logic [4:0]       o_global2_out_delay,
  output logic [4:0]       o_local1_out_delay,
  output logic [4:0]       o_local2_out_delay,
  // phase taps
  output logic [1:0]       o_first_phase_tap_sel,
  output logic [1:0]       o_second_phase_tap_sel,
  // output enables
  output logic             o_primary_global_out_en,
  output logic             o_first_secondary_global_en,
  output logic             o_first_local_out_en,
  output logic             o_second_secondary_global_en,
  output logic             o_second_local_out_en,
  output logic [1:0]       o_global_buffers_used
);

  localparam int LOCK_CYCLES_RAW = (LOCK_TIME_NS * `CLOCK_MHZ + 999) / 1000;
  localparam int LOCK_CYCLES = (LOCK_CYCLES_RAW < 1) ? 1 : LOCK_CYCLES_RAW;
  localparam int LCW = $clog2(LOCK_CYCLES + 1);

  // low two bits pick one of four taps
  function automatic logic [1:0] tap_decode(input logic [2:0] code);
    tap_decode = code[1:0];
  endfunction

  // unused feedback code falls back to direct feedback
  function automatic logic [1:0] fb_decode(input logic [1:0] code);
    fb_decode = (code == 2'(FB_EXTERNAL) || code == 2'(FB_PROG)) ? code : 2'(FB_NONE);
  endfunction

  logic [`CFG_MSB:`CFG_LSB] stage_r;
  logic [`CFG_MSB:`CFG_LSB] active_r;
  logic [1:0]               ref_src_r;
  logic                     sec1_local_r;
  logic                     sec2_local_r;
  logic                     aw_held_r;
  logic                     w_held_r;
  logic [7:0]               aw_addr_r;
  logic [31:0]              w_data_r;
  logic [3:0]               w_strb_r;
  logic                     do_write;
  logic                     sw_update;
  logic                     update;
  logic                     sw_update_r;
  loop_state_t              loop_state_r;
  loop_state_t              loop_state_nxt;
  logic [LCW-1:0]           lock_cnt_r;
  logic [31:0]              rd_data;
  logic                     rd_ok;

  // axi4-lite write path
  assign o_s_axi_awready = !aw_held_r && !o_s_axi_bvalid;
  assign o_s_axi_wready  = !w_held_r && !o_s_axi_bvalid;
  assign do_write        = aw_held_r && w_held_r && !o_s_axi_bvalid;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (i_clk_en) begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= i_s_axi_awaddr;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (i_clk_en) begin
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= i_s_axi_wdata;
        w_strb_r <= i_s_axi_wstrb;
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= `RESP_OKAY;
    end else if (i_clk_en) begin
      if (do_write) begin
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= (8'(aw_addr_r[7:2]) <= (`REG_STATUS >> 2)) ?
                          `RESP_OKAY : `RESP_SLVERR;
      end else if (i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control register: reference source and secondary routing
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ref_src_r    <= 2'(SRC_HARD_PAD);
      sec1_local_r <= 1'b0;
      sec2_local_r <= 1'b0;
    end else if (i_clk_en) begin
      if (do_write && aw_addr_r[7:2] == (`REG_CTRL >> 2) && w_strb_r[0]) begin
        if (w_data_r[`CTRL_SRC_MSB:`CTRL_SRC_LSB] != 2'h3) begin
          ref_src_r <= w_data_r[`CTRL_SRC_MSB:`CTRL_SRC_LSB];
        end
        sec1_local_r <= w_data_r[`CTRL_SEC1_LOC];
        sec2_local_r <= w_data_r[`CTRL_SEC2_LOC];
      end
    end
  end

  assign sw_update = do_write && aw_addr_r[7:2] == (`REG_CTRL >> 2)
                     && w_strb_r[0] && w_data_r[`CTRL_UPDATE];
  assign update    = i_config_update_strobe || sw_update;

  // staging word: serial shift or register writes
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      stage_r <= STATIC_CONFIG;
    end else if (i_clk_en) begin
      if (i_shift_en) begin
        stage_r <= {stage_r[`CFG_MSB-1:`CFG_LSB], i_shift_data};
      end else if (do_write && aw_addr_r[7:2] == (`REG_STAGE_LO >> 2)) begin
        for (int b = 0; b < 4; b++) begin
          if (w_strb_r[b]) begin
            stage_r[`CFG_LSB + 8*b +: 8] <= w_data_r[8*b +: 8];
          end
        end
      end else if (do_write && aw_addr_r[7:2] == (`REG_STAGE_HI >> 2)) begin
        if (w_strb_r[0]) begin
          stage_r[`CFG_LSB + 32 +: 8] <= w_data_r[7:0];
        end
        if (w_strb_r[1]) begin
          stage_r[`CFG_LSB + 40 +: 8] <= w_data_r[15:8];
        end
        if (w_strb_r[2]) begin
          stage_r[`CFG_MSB -: 4] <= w_data_r[19:16];
        end
      end
    end
  end

  assign o_shift_out = stage_r[`CFG_MSB];

  // active word: whole word except the resync bit, which keeps its value, on update strobe
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      active_r <= STATIC_CONFIG;
    end else if (i_clk_en && update) begin
      active_r <= stage_r;
      active_r[`RESYNC_EN_BIT] <= active_r[`RESYNC_EN_BIT];
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sw_update_r      <= 1'b0;
      o_divider_resync <= 1'b0;
    end else if (i_clk_en) begin
      sw_update_r      <= update;
      o_divider_resync <= update && active_r[`RESYNC_EN_BIT];
    end
  end

  // loop lock model
  always_comb begin
    loop_state_nxt = loop_state_r;
    case (loop_state_r)
      LOOP_DOWN: begin
        if (!i_power_down) begin
          loop_state_nxt = LOOP_ACQ;
        end
      end
      LOOP_ACQ: begin
        if (i_power_down) begin
          loop_state_nxt = LOOP_DOWN;
        end else if (lock_cnt_r == LCW'(LOCK_CYCLES - 1)) begin
          loop_state_nxt = LOOP_LOCKED;
        end
      end
      LOOP_LOCKED: begin
        if (i_power_down) begin
          loop_state_nxt = LOOP_DOWN;
        end else if (sw_update_r) begin
          loop_state_nxt = LOOP_ACQ;
        end
      end
      default: loop_state_nxt = LOOP_DOWN;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      loop_state_r <= LOOP_DOWN;
    end else if (i_clk_en) begin
      loop_state_r <= loop_state_nxt;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      lock_cnt_r <= '0;
    end else if (i_clk_en) begin
      if (loop_state_r != LOOP_ACQ || loop_state_nxt != LOOP_ACQ) begin
        lock_cnt_r <= '0;
      end else begin
        lock_cnt_r <= lock_cnt_r + LCW'(1);
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_lock <= 1'b0;
    end else if (i_clk_en) begin
      o_lock <= (loop_state_nxt == LOOP_LOCKED) && !i_power_down;
    end
  end

  // read path
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (i_s_axi_araddr[7:2])
      `REG_CTRL >> 2: begin
        rd_data[`CTRL_SRC_MSB:`CTRL_SRC_LSB] = ref_src_r;
        rd_data[`CTRL_SEC1_LOC] = sec1_local_r;
        rd_data[`CTRL_SEC2_LOC] = sec2_local_r;
      end
      `REG_STAGE_LO >> 2:  rd_data = stage_r[`CFG_LSB +: 32];
      `REG_STAGE_HI >> 2:  rd_data[19:0] = stage_r[`CFG_MSB:`CFG_LSB + 32];
      `REG_ACTIVE_LO >> 2: rd_data = active_r[`CFG_LSB +: 32];
      `REG_ACTIVE_HI >> 2: rd_data[19:0] = active_r[`CFG_MSB:`CFG_LSB + 32];
      `REG_STATUS >> 2: begin
        rd_data[`STAT_LOCK] = o_lock;
        rd_data[`STAT_PD]   = i_power_down;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  assign o_s_axi_arready = !o_s_axi_rvalid;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata  <= 32'h0000_0000;
      o_s_axi_rresp  <= `RESP_OKAY;
    end else if (i_clk_en) begin
      if (i_s_axi_arvalid && o_s_axi_arready) begin
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rdata  <= rd_data;
        o_s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
      end
    end
  end

  // decoded configuration, registered
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_input_c_osc_source_sel <= 1'b0;
      o_input_b_osc_source_sel <= 1'b0;
      o_input_a_osc_source_sel <= 1'b0;
      o_input_c_dynamic_route  <= 1'b0;
      o_input_b_dynamic_route  <= 1'b0;
      o_input_a_dynamic_route  <= 1'b0;
      o_input_c_mux_sel        <= 1'b0;
      o_input_b_mux_sel        <= 1'b0;
      o_input_a_mux_sel        <= 1'b0;
      o_reference_input_a_src  <= 2'(SRC_HARD_PAD);
    end else if (i_clk_en) begin
      o_input_c_osc_source_sel <= active_r[`IN_C_OSC_BIT];
      o_input_b_osc_source_sel <= active_r[`IN_B_OSC_BIT];
      o_input_a_osc_source_sel <= active_r[`IN_A_OSC_BIT];
      o_input_c_dynamic_route  <= active_r[`IN_C_DYN_BIT];
      o_input_b_dynamic_route  <= active_r[`IN_B_DYN_BIT];
      o_input_a_dynamic_route  <= active_r[`IN_A_DYN_BIT];
      o_input_c_mux_sel        <= active_r[`IN_C_MUX_BIT];
      o_input_b_mux_sel        <= active_r[`IN_B_MUX_BIT];
      o_input_a_mux_sel        <= active_r[`IN_A_MUX_BIT];
      o_reference_input_a_src  <= ref_src_r;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_oscillator_gear      <= 3'h0;
      o_system_delay_insert  <= 1'b0;
      o_feedback_delay_value <= 5'h00;
      o_feedback_path_sel    <= 2'(FB_NONE);
      o_first_phase_tap_sel  <= 2'h0;
      o_second_phase_tap_sel <= 2'h0;
    end else if (i_clk_en) begin
      o_oscillator_gear      <= active_r[`GEAR_MSB:`GEAR_LSB];
      o_system_delay_insert  <= active_r[`SYS_DLY_BIT];
      o_feedback_delay_value <= active_r[`FB_DLY_MSB:`FB_DLY_LSB];
      o_feedback_path_sel    <= fb_decode(active_r[`FB_SEL_MSB:`FB_SEL_LSB]);
      o_first_phase_tap_sel  <= tap_decode(active_r[`TAP1_MSB:`TAP1_LSB]);
      o_second_phase_tap_sel <= tap_decode(active_r[`TAP2_MSB:`TAP2_LSB]);
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_primary_out_delay <= 5'h00;
      o_global1_out_delay <= 5'h00;
      o_global2_out_delay <= 5'h00;
      o_local1_out_delay  <= 5'h00;
      o_local2_out_delay  <= 5'h00;
    end else if (i_clk_en) begin
      o_primary_out_delay <= active_r[`PRI_DLY_MSB:`PRI_DLY_LSB];
      o_global1_out_delay <= active_r[`GL1_DLY_MSB:`GL1_DLY_LSB];
      o_global2_out_delay <= active_r[`GL2_DLY_MSB:`GL2_DLY_LSB];
      o_local1_out_delay  <= active_r[`LOC1_DLY_MSB:`LOC1_DLY_LSB];
      o_local2_out_delay  <= active_r[`LOC2_DLY_MSB:`LOC2_DLY_LSB];
    end
  end

  // five outputs, three settings: each secondary pair shares one tap
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_primary_global_out_en      <= 1'b0;
      o_first_secondary_global_en  <= 1'b0;
      o_first_local_out_en         <= 1'b0;
      o_second_secondary_global_en <= 1'b0;
      o_second_local_out_en        <= 1'b0;
      o_global_buffers_used        <= 2'h0;
    end else if (i_clk_en) begin
      o_primary_global_out_en      <= 1'b1;
      o_first_secondary_global_en  <= !sec1_local_r;
      o_first_local_out_en         <= sec1_local_r;
      o_second_secondary_global_en <= !sec2_local_r;
      o_second_local_out_en        <= sec2_local_r;
      // standalone local still holds a buffer
      o_global_buffers_used        <= 2'h3;
    end
  end

endmodule

// ---- verif/clock_conditioner_assertions.sv ----
// clock_conditioner_assertions.sv: port checks of the clock conditioner
`timescale 1ns/1ps
module clock_conditioner_checker (
  // clock and reset
  input wire logic       i_clock,
  input wire logic       i_rst_n,
  input wire logic       i_clk_en,
  // stimulus
  input wire logic       i_power_down,
  input wire logic       i_config_update_strobe,
  input wire logic       i_shift_en,
  input wire logic       i_s_axi_awvalid,
  input wire logic       i_s_axi_wvalid,
  // observed
  input wire logic       o_lock,
  input wire logic       o_divider_resync,
  input wire logic [2:0] o_oscillator_gear,
  input wire logic [4:0] o_primary_out_delay,
  input wire logic [1:0] o_feedback_path_sel,
  input wire logic [1:0] o_global_buffers_used,
  input wire logic       o_primary_global_out_en,
  input wire logic       o_first_secondary_global_en,
  input wire logic       o_first_local_out_en,
  input wire logic       o_second_secondary_global_en,
  input wire logic       o_second_local_out_en
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  property p_pd_lock;
    i_clk_en && i_power_down |=> !o_lock;
  endproperty
  a_pd_lock: assert property (p_pd_lock)
    else $error("lock high during power-down");
  property p_lock_rise;
    $rose(o_lock) |-> !$past(i_power_down) && !$past(i_power_down, 2);
  endproperty
  a_lock_rise: assert property (p_lock_rise)
    else $error("lock rose right after power-down");
  property p_resync;
    o_divider_resync && !i_config_update_strobe |=> !o_divider_resync;
  endproperty
  a_resync: assert property (p_resync)
    else $error("resync pulse longer than one cycle");
  property p_buffers;
    o_primary_global_out_en |-> o_global_buffers_used == 2'h3;
  endproperty
  a_buffers: assert property (p_buffers)
    else $error("global buffer count wrong");
  property p_first_pair;
    o_primary_global_out_en |-> o_first_secondary_global_en != o_first_local_out_en;
  endproperty
  a_first_pair: assert property (p_first_pair)
    else $error("first secondary pair not exclusive");
  property p_second_pair;
    o_primary_global_out_en |-> o_second_secondary_global_en != o_second_local_out_en;
  endproperty
  a_second_pair: assert property (p_second_pair)
    else $error("second secondary pair not exclusive");
  property p_primary;
    $past(i_rst_n, 2) && $past(i_rst_n) |-> o_primary_global_out_en;
  endproperty
  a_primary: assert property (p_primary)
    else $error("primary output not enabled");
  property p_fb_code;
    o_feedback_path_sel != 2'h3;
  endproperty
  a_fb_code: assert property (p_fb_code)
    else $error("feedback select shows unused code");
  property p_hold;
    $past(i_rst_n, 2) && i_clk_en && i_shift_en && !i_config_update_strobe &&
      !i_s_axi_awvalid && !i_s_axi_wvalid && !$past(i_s_axi_awvalid) &&
      !$past(i_s_axi_wvalid) |=> ##1 $stable({o_oscillator_gear, o_primary_out_delay});
  endproperty
  a_hold: assert property (p_hold)
    else $error("configuration changed while shifting");
  c_lock: cover property ($rose(o_lock));
  c_resync: cover property (o_divider_resync);
  c_pd: cover property (i_power_down && !o_lock);
endmodule

bind clock_conditioner clock_conditioner_checker clock_conditioner_checker_inst (.*);

// ---- verif/shift_loader.sv ----
// shift_loader.sv: user-logic model that loads the dynamic shift register
`timescale 1ns/1ps
module shift_loader (
  // clock
  input  wire logic i_clock,
  // serial load port
  output logic      o_shift_en      = 1'b0,
  output logic      o_shift_data    = 1'b0,
  output logic      o_update_strobe = 1'b0
);
  // msb first, idle gaps with data inverted
  task automatic load(input logic [51:0] w, input int gap);
    for (int i = 51; i >= 0; i--) begin
      @(posedge i_clock);
      o_shift_en   <= 1'b1;
      o_shift_data <= w[i];
      repeat (gap) begin
        @(posedge i_clock);
        o_shift_en   <= 1'b0;
        o_shift_data <= ~w[i];
      end
    end
    @(posedge i_clock);
    o_shift_en      <= 1'b0;
    o_shift_data    <= ~w[0];
    o_update_strobe <= 1'b1;
    @(posedge i_clock);
    o_update_strobe <= 1'b0;
  endtask
endmodule

// ---- verif/tb_top.sv ----
// tb_top.sv: self-checking bench of the clock conditioner
`timescale 1ns/1ps
`include "clock_conditioner_map.svh"
module tb_top;
  import clock_conditioner_pkg::*;
  localparam logic [51:0] STAT = 52'h1_2345_6789_ABCD;
  localparam logic [51:0] P1   = 52'hA_6D5A_C3E7_1F9E;
  localparam logic [51:0] P2   = 52'h5_92A5_3C18_E0FB;
  logic        i_clock = 1'b0, i_rst_n = 1'b0, i_clk_en = 1'b1, i_power_down = 1'b0;
  logic        i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
  logic        i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
  logic [7:0]  i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
  logic [31:0] i_s_axi_wdata = 32'h0;
  logic [3:0]  i_s_axi_wstrb = 4'hF;
  wire         i_shift_en, i_shift_data, i_config_update_strobe;
  wire         o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
  wire         o_s_axi_rvalid, o_shift_out, o_lock, o_divider_resync;
  wire [1:0]   o_s_axi_bresp, o_s_axi_rresp;
  wire [31:0]  o_s_axi_rdata;
  wire         o_input_c_osc_source_sel, o_input_b_osc_source_sel, o_input_a_osc_source_sel;
  wire         o_input_c_dynamic_route, o_input_b_dynamic_route, o_input_a_dynamic_route;
  wire         o_input_c_mux_sel, o_input_b_mux_sel, o_input_a_mux_sel;
  wire [1:0]   o_reference_input_a_src, o_feedback_path_sel, o_first_phase_tap_sel;
  wire [1:0]   o_second_phase_tap_sel, o_global_buffers_used;
  wire [2:0]   o_oscillator_gear;
  wire         o_system_delay_insert;
  wire [4:0]   o_feedback_delay_value, o_primary_out_delay, o_global1_out_delay;
  wire [4:0]   o_global2_out_delay, o_local1_out_delay, o_local2_out_delay;
  wire         o_primary_global_out_en, o_first_secondary_global_en, o_first_local_out_en;
  wire         o_second_secondary_global_en, o_second_local_out_en;
  int          bad_count = 0, total_checks = 0;
  always #4 i_clock = ~i_clock;
  clock_conditioner #(.STATIC_CONFIG(STAT), .LOCK_TIME_NS(80)) clock_conditioner_inst (.*);
  shift_loader shift_loader_inst (
    .i_clock         (i_clock),
    .o_shift_en      (i_shift_en),
    .o_shift_data    (i_shift_data),
    .o_update_strobe (i_config_update_strobe)
  );
  task automatic wrap_up;
    if (bad_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int   n;
    logic aw, w, b;
    aw = 0; w = 0; b = 0; n = 0;
    @(posedge i_clock);
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_awaddr  <= a;
    i_s_axi_wvalid  <= 1'b1;
    i_s_axi_wdata   <= d;
    i_s_axi_bready  <= 1'b1;
    while (!b && n < 64) begin
      @(posedge i_clock);
      n++;
      if (o_s_axi_awready) aw = 1;
      if (o_s_axi_wready) w = 1;
      if (o_s_axi_bvalid) b = 1;
      r = o_s_axi_bresp;
      i_s_axi_awvalid <= !aw;
      i_s_axi_wvalid  <= !w;
      i_s_axi_bready  <= !b;
    end
    if (!b) bad_count++;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic ar, rv;
    ar = 0; rv = 0; n = 0;
    @(posedge i_clock);
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_araddr  <= a;
    i_s_axi_rready  <= 1'b1;
    while (!rv && n < 64) begin
      @(posedge i_clock);
      n++;
      if (o_s_axi_arready) ar = 1;
      if (o_s_axi_rvalid) rv = 1;
      d = o_s_axi_rdata;
      r = o_s_axi_rresp;
      i_s_axi_arvalid <= !ar;
      i_s_axi_rready  <= !rv;
    end
    if (!rv) bad_count++;
  endtask
  task automatic check_fields(input logic [83:32] e);
    chk("osc_c", e[`IN_C_OSC_BIT], o_input_c_osc_source_sel);
    chk("osc_b", e[`IN_B_OSC_BIT], o_input_b_osc_source_sel);
    chk("osc_a", e[`IN_A_OSC_BIT], o_input_a_osc_source_sel);
    chk("dyn_c", e[`IN_C_DYN_BIT], o_input_c_dynamic_route);
    chk("dyn_b", e[`IN_B_DYN_BIT], o_input_b_dynamic_route);
    chk("dyn_a", e[`IN_A_DYN_BIT], o_input_a_dynamic_route);
    chk("gear", e[`GEAR_MSB:`GEAR_LSB], o_oscillator_gear);
    chk("mux_c", e[`IN_C_MUX_BIT], o_input_c_mux_sel);
    chk("mux_b", e[`IN_B_MUX_BIT], o_input_b_mux_sel);
    chk("mux_a", e[`IN_A_MUX_BIT], o_input_a_mux_sel);
    chk("loc2", e[`LOC2_DLY_MSB:`LOC2_DLY_LSB], o_local2_out_delay);
    chk("loc1", e[`LOC1_DLY_MSB:`LOC1_DLY_LSB], o_local1_out_delay);
    chk("gl2", e[`GL2_DLY_MSB:`GL2_DLY_LSB], o_global2_out_delay);
    chk("gl1", e[`GL1_DLY_MSB:`GL1_DLY_LSB], o_global1_out_delay);
    chk("pri", e[`PRI_DLY_MSB:`PRI_DLY_LSB], o_primary_out_delay);
    chk("sys", e[`SYS_DLY_BIT], o_system_delay_insert);
    chk("fbd", e[`FB_DLY_MSB:`FB_DLY_LSB], o_feedback_delay_value);
    chk("fbs", e[39:38] === 2'h3 ? 2'h0 : e[39:38], o_feedback_path_sel);
    chk("tap2", e[`TAP2_MSB-1:`TAP2_LSB], o_second_phase_tap_sel);
    chk("tap1", e[`TAP1_MSB-1:`TAP1_LSB], o_first_phase_tap_sel);
  endtask
  task automatic wait_lock(output int n);
    n = 0;
    while (o_lock !== 1'b1 && n < 100) begin
      @(posedge i_clock);
      #1;
      n++;
    end
  endtask
  initial begin
    #40000;
    bad_count++;
    wrap_up();
  end
  initial begin
    logic [83:32] e;
    logic [31:0]  d;
    logic [1:0]   r;
    int           n;
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clock);
    #1;
    check_fields(STAT);
    axi_wr(8'h3C, 32'h0, r);
    chk("wr_unmapped", `RESP_SLVERR, r);
    axi_rd(8'h3C, d, r);
    chk("rd_unmapped", `RESP_SLVERR, r);
    chk("rd_unmapped_data", 32'h0, d);
    e = P1;
    e[80] = STAT[48];
    shift_loader_inst.load(P1, 1);
    #1;
    chk("resync", 1'b1, o_divider_resync);
    @(posedge i_clock);
    #1;
    chk("shift_out", P1[51], o_shift_out);
    check_fields(e);
    chk("resync_end", 1'b0, o_divider_resync);
    axi_rd(`REG_ACTIVE_HI, d, r);
    chk("active_hi", {12'h0, e[83:64]}, d);
    axi_wr(`REG_STAGE_LO, P2[31:0], r);
    axi_wr(`REG_STAGE_HI, {12'h0, P2[51:32]}, r);
    chk("hold_gear", e[`GEAR_MSB:`GEAR_LSB], o_oscillator_gear);
    e = P2;
    e[80] = STAT[48];
    for (int k = 0; k < 3; k++) begin
      axi_wr(`REG_CTRL, {27'h0, k[1], k[0], k[1:0], 1'b1}, r);
      chk("ctrl_resp", `RESP_OKAY, r);
      repeat (2) @(posedge i_clock);
      #1;
      chk("ref_src", k[1:0], o_reference_input_a_src);
      chk("sec1_local", k[0], o_first_local_out_en);
      chk("sec2_global", !k[1], o_second_secondary_global_en);
      chk("primary_en", 1'b1, o_primary_global_out_en);
    end
    check_fields(e);
    axi_rd(`REG_ACTIVE_LO, d, r);
    chk("active_lo", e[63:32], d);
    wait_lock(n);
    chk("lock", 1'b1, o_lock);
    @(posedge i_clock);
    i_power_down <= 1'b1;
    @(posedge i_clock);
    #1;
    chk("lock_pd", 1'b0, o_lock);
    axi_rd(`REG_STATUS, d, r);
    chk("status_pd", 32'h2, d);
    i_power_down <= 1'b0;
    wait_lock(n);
    chk("relock", 1'b1, o_lock);
    chk("relock_time", 1'b1, n >= 10);
    wrap_up();
  end
endmodule
